// >>> cmp_analog_model.sv
// behavioural analog comparator with its pin and reference muxes
`timescale 1ns/10ps

module cmp_analog_model (
	// controls from the block
	input  wire logic        i_power,
	input  wire logic        i_connect,
	input  wire logic [1:0]  i_pos_sel,
	input  wire logic [1:0]  i_ref_sel,
	// four shared pins, millivolts, 12 bits each
	input  wire logic [47:0] i_pins_mv,
	// raw decision
	output logic             o_raw
);
	logic [11:0] pos_mv;
	logic [11:0] neg_mv;

	// positive terminal picks one shared pin
	assign pos_mv = i_pins_mv[12 * i_pos_sel +: 12];
	// reference ladder: nominal, 100 mV below, 100 mV above
	assign neg_mv = (i_ref_sel == 2'h1) ? 12'h4B0 : (i_ref_sel == 2'h2) ? 12'h578 : 12'h514;
	// unpowered or unattached gives a dead low, never a stale decision
	assign o_raw = i_power & i_connect & (pos_mv > neg_mv);
endmodule // cmp_analog_model

// >>> cmp_defs.svh
// constants for the dual comparator event control block
`ifndef CMP_DEFS_SVH
`define CMP_DEFS_SVH

// register byte offsets inside the block window
`define CMP_ADDR_RANGE   7:0
`define CMP_OFF_CTRL_A   8'h00
`define CMP_OFF_CTRL_B   8'h04
`define CMP_OFF_REF      8'h08
`define CMP_OFF_STATUS   8'h0C
`define CMP_OFF_MASK     8'h10
`define CMP_OFF_IRQ_EN   8'h14
`define CMP_OFF_OUT      8'h18

// control/status register fields (one per comparator)
`define CMP_CTRL_MODE    2:0
`define CMP_CTRL_EN      3
`define CMP_CTRL_FLAG    4
`define CMP_CTRL_CONN    5
`define CMP_CTRL_POS     7:6

// reference control register fields
`define CMP_REF_A_REF    1:0
`define CMP_REF_B_REF    3:2
`define CMP_REF_A_SAMP   5:4
`define CMP_REF_B_SAMP   7:6

// interrupt status / mask / enable / output bits
`define CMP_BIT_A        0
`define CMP_BIT_B        1
`define CMP_IRQ_EN_BIT   0

// reset values
`define CMP_CTRL_RST     8'h00
`define CMP_REF_RST      8'h00
`define CMP_IRQ_RST      2'h0
`define CMP_RD_ZERO      32'h00000000
`define CMP_PAD_BYTE     24'h000000
`define CMP_PAD_PAIR     30'h00000000

// interrupt condition codes
`define CMP_MODE_LOW     3'h0
`define CMP_MODE_HIGH    3'h1
`define CMP_MODE_TOG     3'h2
`define CMP_MODE_TOG_DB  3'h3
`define CMP_MODE_FALL    3'h4
`define CMP_MODE_RISE    3'h5
`define CMP_MODE_FALL_DB 3'h6
`define CMP_MODE_RISE_DB 3'h7

// sampling strobe codes
`define CMP_SEL_CLK      2'h0
`define CMP_SEL_T0       2'h1
`define CMP_SEL_T1       2'h2
`define CMP_SEL_T2       2'h3

// negative terminal codes (3 = nominal as well)
`define CMP_REF_NOM      2'h0
`define CMP_REF_LOW      2'h1
`define CMP_REF_HIGH     2'h2

// filter and debounce counts
`define CMP_FILT_LAST    2'h3
`define CMP_FILT_ONE     2'h1
`define CMP_FILT_ZERO    2'h0
`define CMP_DEB_LAST     1'h1

// ahb-lite codes
`define CMP_HTRANS_ACT   1
`define CMP_HSIZE_WORD   3'h2
`define CMP_HRESP_OKAY   1'h0

`endif

// >>> cmp_event.sv
// per-comparator sampling, filtering, debouncing and event detection
`timescale 1ns/10ps
`include "cmp_defs.svh"

module cmp_event (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	// configuration
	input  wire logic       i_active,
	input  wire logic [1:0] i_sample_sel,
	input  wire logic [2:0] i_mode,
	// sources
	input  wire logic       i_cmp,
	input  wire logic [2:0] i_ovf,
	// results
	output logic            o_event,
	output logic            o_out
);

	logic                    cur;
	logic                    strobe;
	logic                    stable_ff;
	logic [1:0]              cnt_ff;
	logic                    edge_ok;
	logic                    rise;
	logic                    fall;
	logic                    debounced;
	logic                    deb_hit;
	logic                    exp_ff;
	logic                    ovf_cnt_ff;
	cmp_pkg::cmp_deb_state_t state_ff;

	// strobe chosen by the sampling-select field
	function automatic logic sel_strobe(input logic [1:0] sel, input logic [2:0] ovf);
		case (sel)
			`CMP_SEL_CLK: sel_strobe = 1'b1;
			`CMP_SEL_T0:  sel_strobe = ovf[0];
			`CMP_SEL_T1:  sel_strobe = ovf[1];
			default:      sel_strobe = ovf[2];
		endcase
	endfunction

	// does a confirmed transition satisfy the edge or toggle condition
	function automatic logic edge_match(input logic [2:0] mode, input logic r, input logic f);
		case (mode)
			`CMP_MODE_TOG, `CMP_MODE_TOG_DB:   edge_match = r | f;
			`CMP_MODE_RISE, `CMP_MODE_RISE_DB: edge_match = r;
			`CMP_MODE_FALL, `CMP_MODE_FALL_DB: edge_match = f;
			default:                           edge_match = 1'b0;
		endcase
	endfunction

	assign cur       = i_active & i_cmp;
	assign strobe    = sel_strobe(i_sample_sel, i_ovf);
	assign debounced = (i_mode == `CMP_MODE_TOG_DB) | (i_mode == `CMP_MODE_FALL_DB) |
	                   (i_mode == `CMP_MODE_RISE_DB);

	// transition accepted at once on the clock strobe, after four equal samples on a timer
	assign edge_ok = strobe & (cur != stable_ff) &
	                 ((i_sample_sel == `CMP_SEL_CLK) | (cnt_ff == `CMP_FILT_LAST));
	assign rise    = edge_ok & cur;
	assign fall    = edge_ok & ~cur;

	// previous accepted sample and the stability counter
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			stable_ff <= 1'b0;
			cnt_ff    <= `CMP_FILT_ZERO;
		end else if (!i_active) begin
			stable_ff <= 1'b0;
			cnt_ff    <= `CMP_FILT_ZERO;
		end else if (strobe) begin
			if (cur == stable_ff || edge_ok) begin
				cnt_ff <= `CMP_FILT_ZERO;
			end else begin
				cnt_ff <= cnt_ff + `CMP_FILT_ONE;
			end
			if (edge_ok) begin
				stable_ff <= cur;
			end
		end
	end

	// resample two timer-1 overflows after an edge; free-running timer means 1..2 periods
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_ff   <= cmp_pkg::DEB_IDLE;
			exp_ff     <= 1'b0;
			ovf_cnt_ff <= 1'b0;
		end else begin
			case (state_ff)
				cmp_pkg::DEB_IDLE: begin
					if (i_active && debounced && i_sample_sel == `CMP_SEL_CLK &&
					    edge_match(i_mode, rise, fall)) begin
						state_ff   <= cmp_pkg::DEB_WAIT;
						exp_ff     <= cur;
						ovf_cnt_ff <= 1'b0;
					end
				end
				cmp_pkg::DEB_WAIT: begin
					if (!i_active || !debounced || i_sample_sel != `CMP_SEL_CLK) begin
						state_ff <= cmp_pkg::DEB_IDLE;
					end else if (i_ovf[1]) begin
						if (ovf_cnt_ff == `CMP_DEB_LAST) begin
							state_ff <= cmp_pkg::DEB_IDLE;
						end else begin
							ovf_cnt_ff <= 1'b1;
						end
					end
				end
				default: state_ff <= cmp_pkg::DEB_IDLE;
			endcase
		end
	end

	assign deb_hit = (state_ff == cmp_pkg::DEB_WAIT) & i_active & debounced &
	                 (i_sample_sel == `CMP_SEL_CLK) & i_ovf[1] &
	                 (ovf_cnt_ff == `CMP_DEB_LAST) & (cur == exp_ff);

	// condition evaluation; nothing fires while the comparator is disabled
	always_comb begin
		o_event = 1'b0;
		case (i_mode)
			`CMP_MODE_LOW:  o_event = strobe & ~cur;
			`CMP_MODE_HIGH: o_event = strobe & cur;
			default: begin
				if (debounced && i_sample_sel == `CMP_SEL_CLK) begin
					o_event = deb_hit;
				end else begin
					o_event = edge_match(i_mode, rise, fall);
				end
			end
		endcase
		o_event = o_event & i_active;
	end

	assign o_out = cur;

endmodule // cmp_event

// >>> cmp_event_ctrl.sv
// top of the dual comparator event control block with its ahb-lite registers
// Functional notes
// - comparator output is one when positive input exceeds negative, else zero
// - bit 3 of each control register enables its own comparator
// - bit 5 connects analog inputs; software sets it before using comparator
// - flag sets when sampled output meets selected level, edge or toggle mode
// - flags readable and raise interrupt; only software writes clear them
// - both flags drive one shared interrupt request; software reads flags
// - two-bit field samples on every clock or timer 0, 1, 2 overflow
// - comparators and events keep running during processor idle
// - comparators forced disabled throughout power-down regardless of enables
// - two-bit field routes one of four shared pins to positive input
// - two-bit field picks reference or levels 100 mV above or below
// - clearing enable forces output low and blocks further flag setting
// - on timer strobes a change needs four stable samples to count
// - debounce on clock strobe resamples after two timer-1 overflows
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
`include "cmp_defs.svh"

module cmp_event_ctrl (
	// clock and reset
	input  wire logic        I_CLOCK,
	input  wire logic        I_NRST,
	// ahb-lite slave
	input  wire logic        I_HSEL,
	input  wire logic [31:0] I_HADDR,
	input  wire logic [1:0]  I_HTRANS,
	input  wire logic        I_HWRITE,
	input  wire logic [2:0]  I_HSIZE,
	input  wire logic [31:0] I_HWDATA,
	input  wire logic        I_HREADY,
	output logic      [31:0] O_HRDATA,
	output logic             O_HREADYOUT,
	output logic             O_HRESP,
	// comparator outputs from the analog macro (asynchronous)
	input  wire logic        I_CMP_A_RAW,
	input  wire logic        I_CMP_B_RAW,
	// timer overflow strobes and power state (same clock)
	input  wire logic        I_T0_OVF,
	input  wire logic        I_T1_OVF,
	input  wire logic        I_T2_OVF,
	input  wire logic        I_PWR_DOWN,
	// comparator a analog controls
	output logic             O_CMP_A_POWER,
	output logic             O_CMP_A_CONNECT,
	output logic      [1:0]  O_CMP_A_POS_SEL,
	output logic      [1:0]  O_CMP_A_REF_SEL,
	// comparator b analog controls
	output logic             O_CMP_B_POWER,
	output logic             O_CMP_B_CONNECT,
	output logic      [1:0]  O_CMP_B_POS_SEL,
	output logic      [1:0]  O_CMP_B_REF_SEL,
	// gated comparator outputs and shared interrupt
	output logic      [1:0]  O_CMP_OUT,
	output logic             O_IRQ
);

	// register state
	logic [7:0]  cmp_a_ctrl_status_ff;
	logic [7:0]  cmp_b_ctrl_status_ff;
	logic [7:0]  cmp_reference_ctrl_ff;
	logic [1:0]  irq_status_ff;
	logic [1:0]  irq_mask_ff;
	logic        cmp_irq_enable_ff;

	// bus pipeline state
	logic        wr_pend_ff;
	logic [7:0]  wr_addr_ff;
	logic        rd_pend_ff;
	logic [7:0]  rd_addr_ff;
	logic [31:0] hrdata_ff;
	logic        hreadyout_ff;
	logic        hresp_ff;

	// output flops
	logic        a_power_ff;
	logic        b_power_ff;
	logic        a_connect_ff;
	logic        b_connect_ff;
	logic [1:0]  cmp_out_ff;
	logic        irq_ff;

	// internal nets
	logic        addr_ok;
	logic [1:0]  cmp_sync;
	logic        a_active;
	logic        b_active;
	logic        a_event;
	logic        b_event;
	logic        a_out;
	logic        b_out;
	logic [2:0]  ovf;
	logic        wr_ctrl_a;
	logic        wr_ctrl_b;
	logic        rd_status;
	logic [31:0] rd_mux;
	logic [1:0]  nxt_irq_status;
	logic        nxt_a_flag;
	logic        nxt_b_flag;

	// register decode shared by the read and write sides
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction

	// flag update: an event in the clearing cycle wins over the clear
	function automatic logic flag_next(input logic flag, input logic evt,
	                                  input logic wr, input logic wbit);
		flag_next = evt | (flag & ~(wr & ~wbit));
	endfunction

	// a transfer is taken only when selected, active and the bus is ready
	assign addr_ok = I_HSEL & I_HTRANS[`CMP_HTRANS_ACT] & I_HREADY;

	// write address phase; only whole-word writes are honoured
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else if (I_HREADY) begin
			wr_pend_ff <= addr_ok & I_HWRITE & (I_HSIZE == `CMP_HSIZE_WORD);
			wr_addr_ff <= I_HADDR[`CMP_ADDR_RANGE];
		end
	end

	// read address phase; one wait state so a write just before is already stored
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			rd_pend_ff <= 1'b0;
			rd_addr_ff <= 8'h00;
		end else begin
			rd_pend_ff <= addr_ok & ~I_HWRITE;
			if (addr_ok && !I_HWRITE) begin
				rd_addr_ff <= I_HADDR[`CMP_ADDR_RANGE];
			end
		end
	end

	// ready drops for the first read data cycle; response is always okay
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			hreadyout_ff <= 1'b1;
			hresp_ff     <= `CMP_HRESP_OKAY;
		end else begin
			hreadyout_ff <= ~(addr_ok & ~I_HWRITE);
			hresp_ff     <= `CMP_HRESP_OKAY;
		end
	end

	// write strobes and the read-clear strobe
	assign wr_ctrl_a = wr_pend_ff & hit(wr_addr_ff, `CMP_OFF_CTRL_A);
	assign wr_ctrl_b = wr_pend_ff & hit(wr_addr_ff, `CMP_OFF_CTRL_B);
	assign rd_status = rd_pend_ff & hit(rd_addr_ff, `CMP_OFF_STATUS);

	// read multiplexer; unmapped offsets read as zero
	always_comb begin
		rd_mux = `CMP_RD_ZERO;
		if (hit(rd_addr_ff, `CMP_OFF_CTRL_A)) begin
			rd_mux = {`CMP_PAD_BYTE, cmp_a_ctrl_status_ff};
		end else if (hit(rd_addr_ff, `CMP_OFF_CTRL_B)) begin
			rd_mux = {`CMP_PAD_BYTE, cmp_b_ctrl_status_ff};
		end else if (hit(rd_addr_ff, `CMP_OFF_REF)) begin
			rd_mux = {`CMP_PAD_BYTE, cmp_reference_ctrl_ff};
		end else if (hit(rd_addr_ff, `CMP_OFF_STATUS)) begin
			rd_mux = {`CMP_PAD_PAIR, irq_status_ff};
		end else if (hit(rd_addr_ff, `CMP_OFF_MASK)) begin
			rd_mux = {`CMP_PAD_PAIR, irq_mask_ff};
		end else if (hit(rd_addr_ff, `CMP_OFF_IRQ_EN)) begin
			rd_mux = {`CMP_PAD_PAIR, 1'b0, cmp_irq_enable_ff};
		end else if (hit(rd_addr_ff, `CMP_OFF_OUT)) begin
			rd_mux = {`CMP_PAD_PAIR, cmp_out_ff};
		end
	end

	// read data held until the next read is taken
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			hrdata_ff <= `CMP_RD_ZERO;
		end else if (rd_pend_ff) begin
			hrdata_ff <= rd_mux;
		end
	end

	// comparator outputs cross into the clock domain
	cmp_sync u_sync (
		.i_clk   (I_CLOCK),
		.i_nrst  (I_NRST),
		.i_async ({I_CMP_B_RAW, I_CMP_A_RAW}),
		.o_sync  (cmp_sync)
	);

	assign ovf = {I_T2_OVF, I_T1_OVF, I_T0_OVF};

	// idle does not appear here on purpose: the block keeps running in idle
	assign a_active = cmp_a_ctrl_status_ff[`CMP_CTRL_EN] & ~I_PWR_DOWN;
	assign b_active = cmp_b_ctrl_status_ff[`CMP_CTRL_EN] & ~I_PWR_DOWN;

	// comparator a event logic
	cmp_event u_event_a (
		.i_clk        (I_CLOCK),
		.i_nrst       (I_NRST),
		.i_active     (a_active),
		.i_sample_sel (cmp_reference_ctrl_ff[`CMP_REF_A_SAMP]),
		.i_mode       (cmp_a_ctrl_status_ff[`CMP_CTRL_MODE]),
		.i_cmp        (cmp_sync[`CMP_BIT_A]),
		.i_ovf        (ovf),
		.o_event      (a_event),
		.o_out        (a_out)
	);

	// comparator b event logic
	cmp_event u_event_b (
		.i_clk        (I_CLOCK),
		.i_nrst       (I_NRST),
		.i_active     (b_active),
		.i_sample_sel (cmp_reference_ctrl_ff[`CMP_REF_B_SAMP]),
		.i_mode       (cmp_b_ctrl_status_ff[`CMP_CTRL_MODE]),
		.i_cmp        (cmp_sync[`CMP_BIT_B]),
		.i_ovf        (ovf),
		.o_event      (b_event),
		.o_out        (b_out)
	);

	// event flags: hardware only sets them, a written zero clears them
	assign nxt_a_flag = flag_next(cmp_a_ctrl_status_ff[`CMP_CTRL_FLAG], a_event,
	                              wr_ctrl_a, I_HWDATA[`CMP_CTRL_FLAG]);
	assign nxt_b_flag = flag_next(cmp_b_ctrl_status_ff[`CMP_CTRL_FLAG], b_event,
	                              wr_ctrl_b, I_HWDATA[`CMP_CTRL_FLAG]);

	// comparator a control register
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			cmp_a_ctrl_status_ff <= `CMP_CTRL_RST;
		end else begin
			if (wr_ctrl_a) begin
				cmp_a_ctrl_status_ff[`CMP_CTRL_POS]  <= I_HWDATA[`CMP_CTRL_POS];
				cmp_a_ctrl_status_ff[`CMP_CTRL_CONN] <= I_HWDATA[`CMP_CTRL_CONN];
				cmp_a_ctrl_status_ff[`CMP_CTRL_EN]   <= I_HWDATA[`CMP_CTRL_EN];
				cmp_a_ctrl_status_ff[`CMP_CTRL_MODE] <= I_HWDATA[`CMP_CTRL_MODE];
			end
			cmp_a_ctrl_status_ff[`CMP_CTRL_FLAG] <= nxt_a_flag;
		end
	end

	// comparator b control register
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			cmp_b_ctrl_status_ff <= `CMP_CTRL_RST;
		end else begin
			if (wr_ctrl_b) begin
				cmp_b_ctrl_status_ff[`CMP_CTRL_POS]  <= I_HWDATA[`CMP_CTRL_POS];
				cmp_b_ctrl_status_ff[`CMP_CTRL_CONN] <= I_HWDATA[`CMP_CTRL_CONN];
				cmp_b_ctrl_status_ff[`CMP_CTRL_EN]   <= I_HWDATA[`CMP_CTRL_EN];
				cmp_b_ctrl_status_ff[`CMP_CTRL_MODE] <= I_HWDATA[`CMP_CTRL_MODE];
			end
			cmp_b_ctrl_status_ff[`CMP_CTRL_FLAG] <= nxt_b_flag;
		end
	end

	// reference and sampling selects; no interlock with connect, software owns that
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			cmp_reference_ctrl_ff <= `CMP_REF_RST;
		end else if (wr_pend_ff && hit(wr_addr_ff, `CMP_OFF_REF)) begin
			cmp_reference_ctrl_ff <= I_HWDATA[7:0];
		end
	end

	// sticky interrupt status: events set, a read clears, set wins
	assign nxt_irq_status = {b_event, a_event} | (irq_status_ff & {2{~rd_status}});

	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			irq_status_ff <= `CMP_IRQ_RST;
		end else begin
			irq_status_ff <= nxt_irq_status;
		end
	end

	// interrupt mask and global comparator interrupt enable
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			irq_mask_ff       <= `CMP_IRQ_RST;
			cmp_irq_enable_ff <= 1'b0;
		end else begin
			if (wr_pend_ff && hit(wr_addr_ff, `CMP_OFF_MASK)) begin
				irq_mask_ff <= I_HWDATA[1:0];
			end
			if (wr_pend_ff && hit(wr_addr_ff, `CMP_OFF_IRQ_EN)) begin
				cmp_irq_enable_ff <= I_HWDATA[`CMP_IRQ_EN_BIT];
			end
		end
	end

	// one shared request; handler reads status or flags to find the source
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= cmp_irq_enable_ff & |(irq_status_ff & irq_mask_ff);
		end
	end

	// analog-side controls; power forced off in power-down
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			a_power_ff   <= 1'b0;
			b_power_ff   <= 1'b0;
			a_connect_ff <= 1'b0;
			b_connect_ff <= 1'b0;
		end else begin
			a_power_ff   <= a_active;
			b_power_ff   <= b_active;
			a_connect_ff <= cmp_a_ctrl_status_ff[`CMP_CTRL_CONN];
			b_connect_ff <= cmp_b_ctrl_status_ff[`CMP_CTRL_CONN];
		end
	end

	// gated comparator outputs, low whenever disabled
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			cmp_out_ff <= 2'h0;
		end else begin
			cmp_out_ff <= {b_out, a_out};
		end
	end

	// bus outputs
	assign O_HRDATA    = hrdata_ff;
	assign O_HREADYOUT = hreadyout_ff;
	assign O_HRESP     = hresp_ff;

	// analog controls straight from register and output flops
	assign O_CMP_A_POWER   = a_power_ff;
	assign O_CMP_A_CONNECT = a_connect_ff;
	assign O_CMP_A_POS_SEL = cmp_a_ctrl_status_ff[`CMP_CTRL_POS];
	assign O_CMP_A_REF_SEL = cmp_reference_ctrl_ff[`CMP_REF_A_REF];
	assign O_CMP_B_POWER   = b_power_ff;
	assign O_CMP_B_CONNECT = b_connect_ff;
	assign O_CMP_B_POS_SEL = cmp_b_ctrl_status_ff[`CMP_CTRL_POS];
	assign O_CMP_B_REF_SEL = cmp_reference_ctrl_ff[`CMP_REF_B_REF];
	assign O_CMP_OUT       = cmp_out_ff;
	assign O_IRQ           = irq_ff;

endmodule // cmp_event_ctrl

// >>> cmp_event_ctrl_monitor.sv
// port assertions for the comparator event control block
`timescale 1ns/10ps

module cmp_event_ctrl_monitor (
	// watched ports
	input wire logic       I_CLOCK,
	input wire logic       I_NRST,
	input wire logic       I_HSEL,
	input wire logic [1:0] I_HTRANS,
	input wire logic       I_HWRITE,
	input wire logic       I_HREADY,
	input wire logic       I_CMP_A_RAW,
	input wire logic       I_PWR_DOWN,
	input wire logic       O_HREADYOUT,
	input wire logic       O_HRESP,
	input wire logic       O_CMP_A_POWER,
	input wire logic       O_CMP_B_POWER,
	input wire logic [1:0] O_CMP_OUT,
	input wire logic       O_IRQ
);
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_NRST);
	logic       take;
	logic [3:0] hist_ff;

	assign take = I_HSEL & I_HTRANS[1] & I_HREADY;
	// recent bus transfers: only software may lower the interrupt
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST)
			hist_ff <= 4'h0;
		else
			hist_ff <= {hist_ff[2:0], take};
	end

	a_read_wait: assert property (take && !I_HWRITE |=> !O_HREADYOUT)
		else $error("read without one wait state");
	a_write_nowait: assert property (take && I_HWRITE |=> O_HREADYOUT)
		else $error("write stalled");
	a_ready_pulse: assert property (!O_HREADYOUT |=> O_HREADYOUT)
		else $error("wait state longer than one cycle");
	a_resp_okay: assert property (O_HRESP == 1'b0)
		else $error("response not okay");
	a_irq_sticky: assert property ($fell(O_IRQ) |-> hist_ff != 4'h0)
		else $error("interrupt dropped with no bus access");
	a_pd_power_off: assert property (I_PWR_DOWN |=> !O_CMP_A_POWER && !O_CMP_B_POWER)
		else $error("comparator powered in power-down");
	a_pd_out_low: assert property (I_PWR_DOWN [*3] |-> O_CMP_OUT == 2'h0)
		else $error("output alive in power-down");
	a_off_out_low: assert property (!O_CMP_A_POWER [*3] |-> !O_CMP_OUT[0])
		else $error("disabled comparator output not low");
	a_out_follows: assert property
		((O_CMP_A_POWER && $stable(I_CMP_A_RAW)) [*4] |-> O_CMP_OUT[0] == I_CMP_A_RAW)
		else $error("output does not follow comparator");

	c_irq: cover property ($rose(O_IRQ));
	c_out_rise: cover property ($rose(O_CMP_OUT[0]));
	c_pd: cover property (I_PWR_DOWN && $fell(O_CMP_A_POWER));
endmodule // cmp_event_ctrl_monitor

bind cmp_event_ctrl cmp_event_ctrl_monitor mon_u (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST),
	.I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY),
	.I_CMP_A_RAW(I_CMP_A_RAW), .I_PWR_DOWN(I_PWR_DOWN), .O_HREADYOUT(O_HREADYOUT),
	.O_HRESP(O_HRESP), .O_CMP_A_POWER(O_CMP_A_POWER), .O_CMP_B_POWER(O_CMP_B_POWER),
	.O_CMP_OUT(O_CMP_OUT), .O_IRQ(O_IRQ));

// >>> cmp_event_ctrl_tb.sv
// self-checking bench for the comparator event control block
`timescale 1ns/10ps

module cmp_event_ctrl_tb;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic [2:0]  ovf = 3'h0;
	logic [2:0]  ovf_req = 3'h0;
	logic        t1_auto = 1'b1;
	logic [4:0]  t1_cnt = 5'h00;
	logic        pwr_dn = 1'b0;
	logic [47:0] pins = 48'h3E83E83E83E8;
	logic [31:0] hrdata, rd;
	logic        hready, hresp, raw_a, raw_b, pw_a, pw_b, con_a, con_b, irq;
	logic [1:0]  pos_a, pos_b, ref_a, ref_b, cmp_out;
	int          err_total = 0;
	int          samples_checked = 0;

	cmp_event_ctrl dut_u (.I_CLOCK(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr),
		.I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
		.I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
		.I_CMP_A_RAW(raw_a), .I_CMP_B_RAW(raw_b), .I_T0_OVF(ovf[0]), .I_T1_OVF(ovf[1]),
		.I_T2_OVF(ovf[2]), .I_PWR_DOWN(pwr_dn), .O_CMP_A_POWER(pw_a),
		.O_CMP_A_CONNECT(con_a), .O_CMP_A_POS_SEL(pos_a), .O_CMP_A_REF_SEL(ref_a),
		.O_CMP_B_POWER(pw_b), .O_CMP_B_CONNECT(con_b), .O_CMP_B_POS_SEL(pos_b),
		.O_CMP_B_REF_SEL(ref_b), .O_CMP_OUT(cmp_out), .O_IRQ(irq));
	cmp_analog_model ana_a_u (.i_power(pw_a), .i_connect(con_a), .i_pos_sel(pos_a),
		.i_ref_sel(ref_a), .i_pins_mv(pins), .o_raw(raw_a));
	cmp_analog_model ana_b_u (.i_power(pw_b), .i_connect(con_b), .i_pos_sel(pos_b),
		.i_ref_sel(ref_b), .i_pins_mv(pins), .o_raw(raw_b));

	initial begin
		forever #2.5 clk = ~clk;
	end

	// timer overflows; timer 1 free-runs, period 32, when asked
	always @(posedge clk) begin
		t1_cnt <= t1_cnt + 5'h01;
		ovf <= ovf_req | {1'b0, t1_auto && t1_cnt == 5'h00, 1'b0};
	end

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		samples_checked++;
		if (got !== ex) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
			err_total++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// bounded wait for hready high at a rising edge
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge clk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 20) begin
				err_total++;
				stop_test();
			end
			@(posedge clk);
		end
	endtask

	// one single word transfer; read data lands in rd
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
		ahb(1'b0, a, 32'h00000000);
		chk(nm, ex, rd);
	endtask

	task automatic pulse(input int s);
		ovf_req <= 3'(1 << (s - 1));
		cyc(1);
		ovf_req <= 3'h0;
		cyc(1);
	endtask

	// settle pin 0, arm mode m, flag cleared, swap the level
	task automatic edge_case(input logic [2:0] m, input logic hi, input logic ex);
		pins[11:0] <= hi ? 12'h5DC : 12'h3E8;
		cyc(70);
		wr(8'h00, {24'h000000, 5'h05, m});
		pins[11:0] <= hi ? 12'h3E8 : 12'h5DC;
		cyc(80);
		rdc("mode_flag", 8'h00, {24'h000000, 2'h0, 1'b1, ex, 1'b1, m});
	endtask

	initial begin
		logic [1:0] p;
		logic [1:0] r;
		cyc(12);
		nrst <= 1'b1;
		for (int a = 0; a < 32; a += 4) rdc("reset_reg", 8'(a), 32'h00000000);
		wr(8'h1C, 32'hFFFFFFFF);
		rdc("unmapped", 8'h1C, 32'h00000000);
		$display("test reset done");
		pins <= 48'h3E83E83E8546;
		for (int i = 0; i < 4; i++) begin
			p = {1'b0, i == 3};
			r = 2'(8'h18 >> (2 * i));
			wr(8'h00, {24'h000000, p, 6'h08});
			wr(8'h08, {30'h00000000, r});
			wr(8'h00, {24'h000000, p, 6'h28});
			cyc(6);
			rdc("out_reg", 8'h18, {31'h00000000, 1'(4'h5 >> i)});
			chk("pos_sel", 32'(p), 32'(pos_a));
			chk("ref_sel", 32'(r), 32'(ref_a));
			chk("power", 32'h1, 32'(pw_a));
		end
		$display("test select done");
		wr(8'h00, 32'h00000008);
		pins <= 48'h3E83E83E83E8;
		for (int m = 0; m < 8; m++) begin
			edge_case(3'(m), 1'b0, 1'(8'hAF >> m));
			edge_case(3'(m), 1'b1, 1'(8'h5F >> m));
		end
		$display("test modes done");
		wr(8'h00, 32'h0000002F);
		pins[11:0] <= 12'h5DC;
		cyc(4);
		pins[11:0] <= 12'h3E8;
		cyc(80);
		rdc("glitch", 8'h00, 32'h0000002F);
		pins[11:0] <= 12'h5DC;
		cyc(80);
		rdc("debounced", 8'h00, 32'h0000003F);
		$display("test debounce done");
		t1_auto <= 1'b0;
		for (int s = 1; s < 4; s++) begin
			wr(8'h08, {26'h0000000, 2'(s), 4'h0});
			pins[11:0] <= 12'h3E8;
			cyc(4);
			repeat (4) pulse(s);
			wr(8'h00, 32'h0000002D);
			pins[11:0] <= 12'h5DC;
			cyc(4);
			repeat (3) pulse(s);
			rdc("strobe3", 8'h00, 32'h0000002D);
			pulse(s);
			cyc(2);
			rdc("strobe4", 8'h00, 32'h0000003D);
		end
		$display("test strobes done");
		pins <= 48'h3E83E83E83E8;
		wr(8'h08, 32'h00000000);
		wr(8'h00, 32'h0000002D);
		wr(8'h04, 32'h000000AD);
		cyc(8);
		ahb(1'b0, 8'h0C, 32'h00000000);
		wr(8'h10, 32'h00000003);
		wr(8'h14, 32'h00000001);
		cyc(4);
		chk("irq_idle", 32'h0, 32'(irq));
		pins[35:24] <= 12'h5DC;
		cyc(10);
		chk("irq_b", 32'h1, 32'(irq));
		rdc("status_b", 8'h0C, 32'h00000002);
		cyc(3);
		chk("irq_clr", 32'h0, 32'(irq));
		rdc("flag_kept", 8'h04, 32'h000000BD);
		wr(8'h04, 32'h000000AD);
		rdc("flag_clr", 8'h04, 32'h000000AD);
		wr(8'h10, 32'h00000002);
		pins[11:0] <= 12'h5DC;
		cyc(10);
		chk("irq_mask", 32'h0, 32'(irq));
		wr(8'h10, 32'h00000003);
		cyc(3);
		chk("irq_a", 32'h1, 32'(irq));
		rdc("status_a", 8'h0C, 32'h00000001);
		$display("test interrupt done");
		pwr_dn <= 1'b1;
		cyc(4);
		chk("pd_power", 32'h0, {30'h00000000, pw_b, pw_a});
		chk("pd_out", 32'h0, 32'(cmp_out));
		pwr_dn <= 1'b0;
		cyc(8);
		chk("wake_out", 32'h3, 32'(cmp_out));
		wr(8'h00, 32'h00000025);
		cyc(4);
		chk("off_out", 32'h2, 32'(cmp_out));
		rdc("off_flag", 8'h00, 32'h00000025);
		$display("test power done");
		stop_test();
	end
endmodule // cmp_event_ctrl_tb

// >>> cmp_pkg.sv
// types shared by the comparator event control modules
package cmp_pkg;

	// debounce sequencer states
	typedef enum logic [0:0] {
		DEB_IDLE,
		DEB_WAIT
	} cmp_deb_state_t;

endpackage

// >>> cmp_sync.sv
// two-stage synchroniser for the comparator outputs
`timescale 1ns/10ps

module cmp_sync (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_nrst,
	// asynchronous in, synchronous out
	input  wire logic [1:0] i_async,
	output logic      [1:0] o_sync
);

	logic [1:0] meta_ff;
	logic [1:0] sync_ff;

	// first stage is read only by the second stage
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_ff <= 2'h0;
			sync_ff <= 2'h0;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;

endmodule // cmp_sync
